// ===== rtl/pcfg_pkg.sv
/*
  Constants for the configuration bank: commands, fields, masks, states.
  Assumes SET_W-wide settings, checksummed in index order.
*/
package pcfg_pkg;

  // ********
  // sizes
  // ********
  localparam int NSET = 13;
  localparam int SET_W = 16;
  localparam int ADDR_W = 7;
  localparam int CRC_NWORDS = NSET + 1;
  localparam int CRC_IDX_W = 4;

  // ********
  // command codes
  // ********
  localparam logic [7:0] CMD_STRAP = 8'hee;
  localparam logic [7:0] CMD_ADDR = 8'hef;
  localparam logic [7:0] CMD_CRC = 8'hf0;
  localparam logic [7:0] CMD_INJ = 8'hf1;
  localparam logic [7:0] RD_FILL_BYTE = 8'hff;
  localparam logic [15:0] RD_FILL_WORD = 16'hffff;

  // ********
  // setting indices
  // ********
  localparam int IDX_STACK = 0;
  localparam int IDX_SYNC = 1;
  localparam int IDX_COMP = 2;
  localparam int IDX_ADDR = 3;
  localparam int IDX_PHASE = 4;
  localparam int IDX_RAMP = 5;
  localparam int IDX_OC_TRIP = 6;
  localparam int IDX_OC_ALERT = 7;
  localparam int IDX_SWITCHING_RATE_SOURCE = 8;
  localparam int IDX_VTARGET = 9;
  localparam int IDX_VDIVIDER = 10;
  localparam int IDX_VCEIL = 11;
  localparam int IDX_VFLOOR = 12;

  // ********
  // strap priority selector fields
  // ********
  localparam int STRAP_STACK_BIT = 12;
  localparam int STRAP_SYNC_BIT = 11;
  localparam int STRAP_COMP_BIT = 9;
  localparam int STRAP_ADDR_BIT = 8;
  localparam int STRAP_PHASE_BIT = 5;
  localparam int STRAP_RAMP_BIT = 3;
  localparam int STRAP_OC_BIT = 2;
  localparam int STRAP_SWITCHING_RATE_SOURCE_BIT = 1;
  localparam int STRAP_VOUT_BIT = 0;
  localparam logic [15:0] STRAP_USED_MASK = 16'h1f3f;
  localparam logic [15:0] STRAP_RESET = 16'h0000;

  // ********
  // fault injection fields
  // ********
  localparam int INJ_FAULT_PERSIST_BIT = 15;
  localparam int INJ_WARN_PERSIST_BIT = 7;
  localparam logic [15:0] INJ_USED_MASK = 16'hdf9b;
  localparam logic [15:0] INJ_FAULT_MASK = 16'h5f00;
  localparam logic [15:0] INJ_WARN_MASK = 16'h001b;
  localparam logic [15:0] INJ_ANYTIME_MASK = 16'h0900;

  // ********
  // address and checksum
  // ********
  localparam logic [ADDR_W-1:0] RSV_ADDR_A = 7'h0c;
  localparam logic [ADDR_W-1:0] RSV_ADDR_B = 7'h28;
  localparam logic [ADDR_W-1:0] RSV_ADDR_C = 7'h37;
  localparam logic [ADDR_W-1:0] RSV_ADDR_D = 7'h61;
  localparam logic [15:0] CRC_POLY = 16'h8005;
  localparam logic [15:0] CRC_INIT = 16'h0000;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_ADDR = 6'b000010,
    ST_CMD = 6'b000100,
    ST_WR = 6'b001000,
    ST_RD = 6'b010000,
    ST_IGN = 6'b100000
  } pcfg_bus_state_type;

  function automatic int strap_bit_of(input int idx);
    case (idx)
      IDX_STACK: strap_bit_of = STRAP_STACK_BIT;
      IDX_SYNC: strap_bit_of = STRAP_SYNC_BIT;
      IDX_COMP: strap_bit_of = STRAP_COMP_BIT;
      IDX_ADDR: strap_bit_of = STRAP_ADDR_BIT;
      IDX_PHASE: strap_bit_of = STRAP_PHASE_BIT;
      IDX_RAMP: strap_bit_of = STRAP_RAMP_BIT;
      IDX_OC_TRIP: strap_bit_of = STRAP_OC_BIT;
      IDX_OC_ALERT: strap_bit_of = STRAP_OC_BIT;
      IDX_SWITCHING_RATE_SOURCE: strap_bit_of = STRAP_SWITCHING_RATE_SOURCE_BIT;
      default: strap_bit_of = STRAP_VOUT_BIT;
    endcase
  endfunction

  function automatic logic is_reserved_addr(input logic [ADDR_W-1:0] a);
    is_reserved_addr = (a == RSV_ADDR_A) || (a == RSV_ADDR_B) ||
                       (a == RSV_ADDR_C) || (a == RSV_ADDR_D);
  endfunction

endpackage

// ===== rtl/pcfg_crc_if.sv
/*
  Carrier between register bank and checksum engine.
  Assumes one clock; the user side supplies words by index.
*/
`timescale 1ns/10ps
interface pcfg_crc_if #(
  parameter int IDX_W = 4
);
  logic start;
  logic busy;
  logic done;
  logic [IDX_W-1:0] idx;
  logic [15:0] word;
  logic [15:0] crc;

  modport eng (input start, input word, output busy, output done, output idx, output crc);
  modport user (output start, output word, input busy, input done, input idx, input crc);
endinterface

// ===== rtl/pcfg_crc_engine.sv
/*
  Bit-serial checksum engine, one bit a cycle over CRC_NWORDS words.
  Assumes word[idx] is presented combinationally.
*/
`timescale 1ns/10ps
module pcfg_crc_engine (
  input wire logic clock_i,        // device clock
  input wire logic rst_i,          // async reset, active high
  pcfg_crc_if.eng crc_port         // start, word feed, result
);

  typedef struct packed {
    logic busy;
    logic done;
    logic [pcfg_pkg::CRC_IDX_W-1:0] idx;
    logic [3:0] bitc;
    logic [15:0] acc;
    logic [15:0] crc;
  } pcfg_crc_state_type;

  pcfg_crc_state_type s_q;
  pcfg_crc_state_type s_d;
  logic fb;

  always_comb
  begin
    s_d = s_q;
    s_d.done = 1'b0;
    fb = s_q.acc[15] ^ crc_port.word[~s_q.bitc];
    if (crc_port.start)
    begin
      // a fresh request restarts a walk in progress
      s_d.busy = 1'b1;
      s_d.idx = '0;
      s_d.bitc = '0;
      s_d.acc = pcfg_pkg::CRC_INIT;
    end
    else if (s_q.busy)
    begin
      s_d.acc = {s_q.acc[14:0], 1'b0} ^ (fb ? pcfg_pkg::CRC_POLY : 16'h0000);
      s_d.bitc = s_q.bitc + 4'd1;
      if (s_q.bitc == 4'hf)
      begin
        if (s_q.idx == pcfg_pkg::CRC_IDX_W'(pcfg_pkg::CRC_NWORDS - 1))
        begin
          s_d.busy = 1'b0;
          s_d.done = 1'b1;
          s_d.crc = s_d.acc;
        end
        else
        begin
          s_d.idx = s_q.idx + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign crc_port.busy = s_q.busy;
  assign crc_port.done = s_q.done;
  assign crc_port.idx = s_q.idx;
  assign crc_port.crc = s_q.crc;

endmodule

// ===== rtl/pcfg_regs.sv
/*
  Configuration registers behind the bus pins, with a serial slave engine
  sampling scl and sda on the device clock.
  Assumes open-drain bus lines resolved outside, stable stored and strapped
  settings, and one-cycle restore, store-done and fault-response pulses.
*/
`timescale 1ns/10ps

// Functional notes
// - selector bit 12 picks strap or stored source for multiphase arrangement
// - selector bit 11 picks strap or stored source for clock-follow setup
// - selector bit 9 picks strap or stored loop compensation
// - selector bit 8 picks strap or stored bus target address
// - selector bit 5 picks strap or stored phase offset setting
// - selector bit 3 picks strap or stored soft-start ramp time
// - selector bit 2 picks strap or stored overcurrent trip and alert levels
// - selector bit 1 picks strap or stored switching rate
// - selector bit 0 picks strap or stored output voltage group
// - selector choices apply at power-on and at every restore command
// - identifier is one byte, 7-bit address, bit 7 reads zero
// - a new address is answered from the next transaction on
// - reserved addresses 0x0C, 0x28, 0x37, 0x61 are refused as invalid
// - read-only word gives CRC-16, polynomial 0x8005, over stored settings then stored selector
// - checksum recomputed at boot and after each store or restore
// - each injection bit forces its detector output, several at once
// - injection register is word wide, word access, not stored
// - bit 15 clear: injected faults drop after one fault response
// - bit 7 clear: injected warnings drop after one fault response
// - only input lockout and output overvoltage act while conversion is off
// - injection bit map for faults 14,12..8 and warnings 4,3,1,0
module pcfg_regs #(
  parameter int NSET = pcfg_pkg::NSET,
  parameter int SET_W = pcfg_pkg::SET_W
) (
  input wire logic clock_i,                               // device clock
  input wire logic rst_i,                                 // async reset, active high
  input wire logic scl_i,                                 // bus clock pin
  input wire logic sda_i,                                 // bus data pin level
  output logic sda_o,                                     // bus data drive value
  output logic sda_oe_n_o,                                // low while pulling sda
  input wire logic [NSET-1:0][SET_W-1:0] nvm_set_i,       // stored settings
  input wire logic [NSET-1:0][SET_W-1:0] pin_set_i,       // pin-detected settings
  input wire logic [15:0] nvm_strap_i,                    // stored selector
  input wire logic load_req_i,                            // restore user settings
  input wire logic store_done_i,                          // store finished
  input wire logic conv_en_i,                             // conversion enabled
  input wire logic fault_response_i,                      // one fault response done
  output logic [NSET-1:0][SET_W-1:0] set_o,               // active settings
  output logic [SET_W-1:0] multiphase_arrangement_o,      // stack setting
  output logic [SET_W-1:0] clock_follow_setup_o,          // sync setting
  output logic [SET_W-1:0] loop_compensation_setting_o,   // compensation
  output logic [SET_W-1:0] phase_offset_setting_o,        // phase_offset_setting
  output logic [SET_W-1:0] soft_start_ramp_time_o,        // ramp time
  output logic [SET_W-1:0] overcurrent_trip_level_o,      // oc fault level
  output logic [SET_W-1:0] overcurrent_alert_level_o,     // oc warn level
  output logic [SET_W-1:0] switching_rate_source_o,       // switching rate
  output logic [SET_W-1:0] output_voltage_target_o,       // vout target
  output logic [SET_W-1:0] feedback_divider_ratio_o,      // divider ratio
  output logic [SET_W-1:0] output_voltage_ceiling_o,      // vout ceiling
  output logic [SET_W-1:0] output_voltage_floor_o,        // vout floor
  output logic [pcfg_pkg::ADDR_W-1:0] bus_addr_o,         // current target address
  output logic [15:0] strap_sel_o,                        // selector value
  output logic [15:0] settings_crc_o,                     // checksum value
  output logic crc_busy_o,                                // checksum walk running
  output logic [15:0] inject_force_o,                     // forced detector outputs
  output logic invalid_data_o                             // refused write, pulse
);

  // ********
  // state
  // ********
  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_p;
    logic sda_s1;
    logic sda_s2;
    logic sda_p;
    pcfg_pkg::pcfg_bus_state_type state;
    logic [3:0] bit_cnt;
    logic ack_ph;
    logic mnack;
    logic drive;
    logic [7:0] sh;
    logic [7:0] tx;
    logic [7:0] cmd;
    logic [1:0] wcnt;
    logic [1:0] byte_idx;
    logic [15:0] wbuf;
    logic [15:0] rword;
    logic [15:0] strap;
    logic [NSET-1:0][SET_W-1:0] set;
    logic [15:0] inject;
    logic [15:0] force_out;
    logic boot;
    logic crc_go;
    logic invalid;
  } pcfg_top_state_type;

  pcfg_top_state_type r_q;
  pcfg_top_state_type r_d;
  logic rise;
  logic fall;
  logic start_cond;
  logic stop_cond;
  logic [7:0] rd_byte;
  logic [15:0] rd_word;
  logic word_cmd;
  logic [pcfg_pkg::ADDR_W-1:0] my_addr;

  pcfg_crc_if #(.IDX_W(pcfg_pkg::CRC_IDX_W)) crc_if ();

  pcfg_crc_engine u_crc (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .crc_port(crc_if.eng)
  );

  // ********
  // checksum feed
  // ********
  assign crc_if.start = r_q.crc_go;
  assign crc_if.word = (crc_if.idx < pcfg_pkg::CRC_IDX_W'(NSET)) ? nvm_set_i[crc_if.idx] :
                       nvm_strap_i;

  // ********
  // read data selection
  // ********
  assign my_addr = r_q.set[pcfg_pkg::IDX_ADDR][pcfg_pkg::ADDR_W-1:0];
  assign word_cmd = (r_q.cmd != pcfg_pkg::CMD_ADDR);

  always_comb
  begin
    case (r_q.cmd)
      pcfg_pkg::CMD_STRAP: rd_word = r_q.strap;
      pcfg_pkg::CMD_ADDR: rd_word = {9'h000, my_addr};
      pcfg_pkg::CMD_CRC: rd_word = crc_if.crc;
      pcfg_pkg::CMD_INJ: rd_word = r_q.inject;
      default: rd_word = pcfg_pkg::RD_FILL_WORD;
    endcase
    if (r_q.byte_idx == 2'd0)
    begin
      rd_byte = r_q.rword[7:0];
    end
    else if (r_q.byte_idx == 2'd1 && word_cmd)
    begin
      rd_byte = r_q.rword[15:8];
    end
    else
    begin
      rd_byte = pcfg_pkg::RD_FILL_BYTE;
    end
  end

  // ********
  // next state
  // ********
  assign rise = r_q.scl_s2 & ~r_q.scl_p;
  assign fall = ~r_q.scl_s2 & r_q.scl_p;
  assign start_cond = r_q.scl_s2 & r_q.scl_p & r_q.sda_p & ~r_q.sda_s2;
  assign stop_cond = r_q.scl_s2 & r_q.scl_p & ~r_q.sda_p & r_q.sda_s2;

  always_comb
  begin
    r_d = r_q;
    r_d.invalid = 1'b0;
    r_d.crc_go = 1'b0;
    r_d.scl_s1 = scl_i;
    r_d.scl_s2 = r_q.scl_s1;
    r_d.scl_p = r_q.scl_s2;
    r_d.sda_s1 = sda_i;
    r_d.sda_s2 = r_q.sda_s1;
    r_d.sda_p = r_q.sda_s2;

    // power-on and restore load with strap priority
    if (r_q.boot || load_req_i)
    begin
      r_d.boot = 1'b0;
      r_d.strap = nvm_strap_i & pcfg_pkg::STRAP_USED_MASK;
      for (int i = 0; i < NSET; i++)
      begin
        r_d.set[i] = nvm_strap_i[pcfg_pkg::strap_bit_of(i)] ? pin_set_i[i] : nvm_set_i[i];
      end
      r_d.crc_go = 1'b1;
    end
    if (store_done_i)
    begin
      r_d.crc_go = 1'b1;
    end

    // auto clear of injections after a fault response
    if (fault_response_i)
    begin
      if (!r_q.inject[pcfg_pkg::INJ_FAULT_PERSIST_BIT])
      begin
        r_d.inject = r_d.inject & ~pcfg_pkg::INJ_FAULT_MASK;
      end
      if (!r_q.inject[pcfg_pkg::INJ_WARN_PERSIST_BIT])
      begin
        r_d.inject = r_d.inject & ~pcfg_pkg::INJ_WARN_MASK;
      end
    end

    // forced detector outputs
    r_d.force_out = r_q.inject & (conv_en_i ? (pcfg_pkg::INJ_FAULT_MASK | pcfg_pkg::INJ_WARN_MASK)
                                            : pcfg_pkg::INJ_ANYTIME_MASK);

    // serial slave engine
    if (start_cond)
    begin
      r_d.state = pcfg_pkg::ST_ADDR;
      r_d.bit_cnt = 4'd0;
      r_d.ack_ph = 1'b0;
      r_d.mnack = 1'b0;
      r_d.drive = 1'b0;
    end
    else if (stop_cond)
    begin
      if (r_q.state == pcfg_pkg::ST_WR)
      begin
        // commit at stop; a write here beats the response clear above
        case (r_q.cmd)
          pcfg_pkg::CMD_STRAP:
          begin
            if (r_q.wcnt == 2'd2)
            begin
              r_d.strap = r_q.wbuf & pcfg_pkg::STRAP_USED_MASK;
            end
            else
            begin
              r_d.invalid = 1'b1;
            end
          end
          pcfg_pkg::CMD_ADDR:
          begin
            if (r_q.wcnt == 2'd1 && !pcfg_pkg::is_reserved_addr(r_q.wbuf[6:0]))
            begin
              r_d.set[pcfg_pkg::IDX_ADDR] = SET_W'(r_q.wbuf[pcfg_pkg::ADDR_W-1:0]);
            end
            else
            begin
              r_d.invalid = 1'b1;
            end
          end
          pcfg_pkg::CMD_INJ:
          begin
            if (r_q.wcnt == 2'd2)
            begin
              r_d.inject = r_q.wbuf & pcfg_pkg::INJ_USED_MASK;
            end
            else
            begin
              r_d.invalid = 1'b1;
            end
          end
          pcfg_pkg::CMD_CRC:
          begin
            r_d.invalid = 1'b1;
          end
          default:
          begin
          end
        endcase
      end
      r_d.state = pcfg_pkg::ST_IDLE;
      r_d.drive = 1'b0;
      r_d.ack_ph = 1'b0;
    end
    else if (rise)
    begin
      if (r_q.ack_ph)
      begin
        if (r_q.state == pcfg_pkg::ST_RD)
        begin
          r_d.mnack = r_q.sda_s2;
        end
      end
      else if (r_q.bit_cnt < 4'd8 && r_q.state != pcfg_pkg::ST_IDLE &&
               r_q.state != pcfg_pkg::ST_IGN)
      begin
        r_d.sh = {r_q.sh[6:0], r_q.sda_s2};
        r_d.bit_cnt = r_q.bit_cnt + 4'd1;
      end
    end
    else if (fall)
    begin
      if (r_q.ack_ph)
      begin
        r_d.ack_ph = 1'b0;
        r_d.drive = 1'b0;
        r_d.bit_cnt = 4'd0;
        if (r_q.state == pcfg_pkg::ST_RD)
        begin
          if (r_q.mnack)
          begin
            r_d.state = pcfg_pkg::ST_IGN;
          end
          else
          begin
            r_d.tx = rd_byte;
            r_d.drive = ~rd_byte[7];
            r_d.byte_idx = (r_q.byte_idx == 2'd3) ? 2'd3 : r_q.byte_idx + 2'd1;
          end
        end
      end
      else if (r_q.bit_cnt == 4'd8)
      begin
        case (r_q.state)
          pcfg_pkg::ST_ADDR:
          begin
            if (r_q.sh[7:1] == my_addr)
            begin
              r_d.ack_ph = 1'b1;
              r_d.drive = 1'b1;
              if (r_q.sh[0])
              begin
                r_d.state = pcfg_pkg::ST_RD;
                r_d.byte_idx = 2'd0;
                r_d.rword = rd_word;
              end
              else
              begin
                r_d.state = pcfg_pkg::ST_CMD;
              end
            end
            else
            begin
              r_d.state = pcfg_pkg::ST_IGN;
            end
          end
          pcfg_pkg::ST_CMD:
          begin
            r_d.cmd = r_q.sh;
            r_d.wcnt = 2'd0;
            r_d.state = pcfg_pkg::ST_WR;
            r_d.ack_ph = 1'b1;
            r_d.drive = 1'b1;
          end
          pcfg_pkg::ST_WR:
          begin
            // low byte first
            if (r_q.wcnt == 2'd0)
            begin
              r_d.wbuf[7:0] = r_q.sh;
            end
            else if (r_q.wcnt == 2'd1)
            begin
              r_d.wbuf[15:8] = r_q.sh;
            end
            r_d.wcnt = (r_q.wcnt == 2'd3) ? 2'd3 : r_q.wcnt + 2'd1;
            r_d.ack_ph = 1'b1;
            r_d.drive = 1'b1;
          end
          pcfg_pkg::ST_RD:
          begin
            r_d.ack_ph = 1'b1;
            r_d.drive = 1'b0;
          end
          default:
          begin
          end
        endcase
      end
      else if (r_q.state == pcfg_pkg::ST_RD && r_q.bit_cnt != 4'd0)
      begin
        r_d.tx = {r_q.tx[6:0], 1'b0};
        r_d.drive = ~r_q.tx[6];
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      r_q <= '0;
      r_q.state <= pcfg_pkg::ST_IDLE;
      r_q.strap <= pcfg_pkg::STRAP_RESET;
      r_q.boot <= 1'b1;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  // ********
  // outputs
  // ********
  assign sda_o = 1'b0;
  assign sda_oe_n_o = ~r_q.drive;
  assign set_o = r_q.set;
  assign multiphase_arrangement_o = r_q.set[pcfg_pkg::IDX_STACK];
  assign clock_follow_setup_o = r_q.set[pcfg_pkg::IDX_SYNC];
  assign loop_compensation_setting_o = r_q.set[pcfg_pkg::IDX_COMP];
  assign phase_offset_setting_o = r_q.set[pcfg_pkg::IDX_PHASE];
  assign soft_start_ramp_time_o = r_q.set[pcfg_pkg::IDX_RAMP];
  assign overcurrent_trip_level_o = r_q.set[pcfg_pkg::IDX_OC_TRIP];
  assign overcurrent_alert_level_o = r_q.set[pcfg_pkg::IDX_OC_ALERT];
  assign switching_rate_source_o = r_q.set[pcfg_pkg::IDX_SWITCHING_RATE_SOURCE];
  assign output_voltage_target_o = r_q.set[pcfg_pkg::IDX_VTARGET];
  assign feedback_divider_ratio_o = r_q.set[pcfg_pkg::IDX_VDIVIDER];
  assign output_voltage_ceiling_o = r_q.set[pcfg_pkg::IDX_VCEIL];
  assign output_voltage_floor_o = r_q.set[pcfg_pkg::IDX_VFLOOR];
  assign bus_addr_o = my_addr;
  assign strap_sel_o = r_q.strap;
  assign settings_crc_o = crc_if.crc;
  assign crc_busy_o = crc_if.busy;
  assign inject_force_o = r_q.force_out;
  assign invalid_data_o = r_q.invalid;

endmodule

// ===== tb/pcfg_regs_asserts.sv
/*
  Port assertions for the configuration bank.
  Assumes binding to pcfg_regs on one clock domain.
*/
`timescale 1ns/10ps
module pcfg_regs_asserts #(
  parameter int NSET = 13,
  parameter int SET_W = 16
) (
  input wire logic clock_i, // clock
  input wire logic rst_i, // reset
  input wire logic [NSET-1:0][SET_W-1:0] nvm_set_i, // stored
  input wire logic [NSET-1:0][SET_W-1:0] pin_set_i, // strapped
  input wire logic [15:0] nvm_strap_i, // selector
  input wire logic load_req_i, // restore
  input wire logic store_done_i, // store
  input wire logic conv_en_i, // enable
  input wire logic [SET_W-1:0] multiphase_arrangement_o, // stack
  input wire logic [SET_W-1:0] overcurrent_trip_level_o, // trip
  input wire logic [SET_W-1:0] overcurrent_alert_level_o, // alert
  input wire logic [SET_W-1:0] switching_rate_source_o, // rate
  input wire logic [SET_W-1:0] output_voltage_target_o, // target
  input wire logic [pcfg_pkg::ADDR_W-1:0] bus_addr_o, // address
  input wire logic crc_busy_o, // walk
  input wire logic [15:0] inject_force_o // forced
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);
  // source chosen by selector bit b
  function automatic logic [15:0] pick(input int i, input int b);
    return nvm_strap_i[b] ? pin_set_i[i] : nvm_set_i[i];
  endfunction
  sequence s_walk;
    ##[1:3] crc_busy_o ##1 crc_busy_o [*8];
  endsequence
  property p_stack;
    load_req_i |=> multiphase_arrangement_o == pick(0, 12);
  endproperty
  a_stack: assert property (p_stack) else $error("stack source");
  property p_addr;
    load_req_i |=> {9'h000, bus_addr_o} == (pick(3, 8) & 16'h007f);
  endproperty
  a_addr: assert property (p_addr) else $error("address source");
  property p_oc;
    load_req_i |=> {overcurrent_trip_level_o, overcurrent_alert_level_o} ==
      {pick(6, 2), pick(7, 2)};
  endproperty
  a_oc: assert property (p_oc) else $error("overcurrent source");
  property p_rate;
    load_req_i |=> switching_rate_source_o == pick(8, 1);
  endproperty
  a_rate: assert property (p_rate) else $error("rate source");
  property p_vout;
    load_req_i |=> output_voltage_target_o == pick(9, 0);
  endproperty
  a_vout: assert property (p_vout) else $error("vout source");
  property p_crc;
    store_done_i |-> s_walk;
  endproperty
  a_crc: assert property (p_crc) else $error("checksum not rerun");
  property p_off;
    !conv_en_i |=> (inject_force_o & 16'hf6ff) == 16'h0000;
  endproperty
  a_off: assert property (p_off) else $error("force while off");
  property p_map;
    (inject_force_o & 16'ha0e4) == 16'h0000;
  endproperty
  a_map: assert property (p_map) else $error("force on unused bit");
endmodule

bind pcfg_regs pcfg_regs_asserts #(.NSET(NSET), .SET_W(SET_W)) pcfg_regs_asserts_inst (
  .clock_i, .rst_i, .nvm_set_i, .pin_set_i, .nvm_strap_i, .load_req_i, .store_done_i,
  .conv_en_i, .multiphase_arrangement_o, .overcurrent_trip_level_o,
  .overcurrent_alert_level_o, .switching_rate_source_o, .output_voltage_target_o,
  .bus_addr_o, .crc_busy_o, .inject_force_o
);

// ===== tb/pcfg_hm.sv
/*
  Bus host model: write and read sequences.
  Assumes sda is pulled up; device pulls while its enable is low.
*/
`timescale 1ns/10ps
module pcfg_hm (
  input wire logic oe_n_i, // device enable
  input wire logic dev_i, // device value
  output logic scl_o, // bus clock
  output logic sda_o // line level
);
  logic drv = 1'b1;
  logic aok;
  initial scl_o = 1'b1;
  assign sda_o = drv & (oe_n_i | dev_i);
  task automatic start();
    #40 drv = 1'b1;
    #40 scl_o = 1'b1;
    #40 drv = 1'b0;
    #40 scl_o = 1'b0;
  endtask
  task automatic stop();
    #16 drv = 1'b0;
    #40 scl_o = 1'b1;
    #40 drv = 1'b1;
    #80;
  endtask
  task automatic bit_io(input logic b, output logic r);
    #16 drv = b;
    #24 scl_o = 1'b1;
    #38 r = sda_o;
    #2 scl_o = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] d, input logic l, output logic [7:0] q,
    output logic k);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(l, k);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [15:0] d,
    input int n);
    logic [7:0] q;
    logic k;
    start();
    xfer({a, 1'b0}, 1'b1, q, k);
    aok = !k;
    xfer(c, 1'b1, q, k);
    for (int i = 0; i < n; i++)
      xfer(d[8*i +: 8], 1'b1, q, k);
    stop();
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] c, input int n,
    output logic [15:0] d);
    logic [7:0] q;
    logic k;
    d = 16'h0000;
    start();
    xfer({a, 1'b0}, 1'b1, q, k);
    aok = !k;
    xfer(c, 1'b1, q, k);
    start();
    xfer({a, 1'b1}, 1'b1, q, k);
    for (int i = 0; i < n; i++)
    begin
      xfer(8'hff, i == n - 1, q, k);
      d[8*i +: 8] = q;
    end
    stop();
  endtask
endmodule

// ===== tb/testbench.sv
/*
  Bank tests: source select, checksum, address, injection.
  Assumes the host model drives the bus pins.
*/
`timescale 1ns/10ps
module testbench;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic ld = 1'b0;
  logic sd = 1'b0;
  logic ce = 1'b1;
  logic fr = 1'b0;
  logic [12:0][15:0] nvm;
  logic [12:0][15:0] pin;
  logic [12:0][15:0] set;
  logic [15:0] strap = 16'h0000;
  logic [15:0] crc;
  logic [15:0] frc;
  logic [15:0] ssel;
  logic [15:0] d;
  logic [6:0] addr;
  logic busy;
  logic inv;
  wire scl;
  wire sda;
  wire oe_n;
  wire sdo;
  wire [12:0][15:0] nm;
  int n_fail = 0;
  int num_checks = 0;
  int n_inv = 0;
  int sb[13] = '{12, 11, 9, 8, 5, 3, 2, 2, 1, 0, 0, 0, 0};
  int ni[7] = '{1, 2, 4, 5, 10, 11, 12};
  logic [15:0] pat[2] = '{16'h1225, 16'h090a};
  logic [6:0] rsv[4] = '{7'h0c, 7'h28, 7'h37, 7'h61};
  always #4 clock_i = ~clock_i;
  always @(posedge clock_i) n_inv <= n_inv + int'(inv);
  pcfg_regs pcfg_regs_inst (
    .clock_i(clock_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda), .sda_o(sdo),
    .sda_oe_n_o(oe_n), .nvm_set_i(nvm), .pin_set_i(pin), .nvm_strap_i(strap),
    .load_req_i(ld), .store_done_i(sd), .conv_en_i(ce), .fault_response_i(fr),
    .set_o(set), .multiphase_arrangement_o(), .clock_follow_setup_o(nm[1]),
    .loop_compensation_setting_o(nm[2]), .phase_offset_setting_o(nm[4]),
    .soft_start_ramp_time_o(nm[5]), .overcurrent_trip_level_o(),
    .overcurrent_alert_level_o(), .switching_rate_source_o(),
    .output_voltage_target_o(), .feedback_divider_ratio_o(nm[10]),
    .output_voltage_ceiling_o(nm[11]), .output_voltage_floor_o(nm[12]), .bus_addr_o(addr),
    .strap_sel_o(ssel), .settings_crc_o(crc), .crc_busy_o(busy),
    .inject_force_o(frc), .invalid_data_o(inv)
  );
  pcfg_hm h (.oe_n_i(oe_n), .dev_i(sdo), .scl_o(scl), .sda_o(sda));
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic pulse(ref logic s);
    @(negedge clock_i);
    s = 1'b1;
    @(negedge clock_i);
    s = 1'b0;
  endtask
  task automatic idle();
    repeat (400) if (busy) @(negedge clock_i);
  endtask
  function automatic logic [15:0] crc16();
    logic [15:0] c;
    logic fb;
    c = 16'h0000;
    for (int w = 0; w < 14; w++)
      for (int b = 15; b >= 0; b--)
      begin
        fb = c[15] ^ (w < 13 ? nvm[w][b] : strap[b]);
        c = {c[14:0], 1'b0} ^ (fb ? 16'h8005 : 16'h0000);
      end
    return c;
  endfunction
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    for (int i = 0; i < 13; i++)
    begin
      nvm[i] = 16'h1010 + 16'(i);
      pin[i] = 16'h2040 + 16'(i);
    end
    repeat (20) @(negedge clock_i);
    rst_i = 1'b0;
    repeat (300) @(negedge clock_i);
    foreach (pat[k])
    begin
      strap = pat[k];
      pulse(ld);
      @(negedge clock_i);
      for (int i = 0; i < 13; i++)
        chk("setting", set[i], strap[sb[i]] ? pin[i] : nvm[i]);
      foreach (ni[j])
        chk("named", nm[ni[j]], strap[sb[ni[j]]] ? pin[ni[j]] : nvm[ni[j]]);
    end
    idle();
    chk("crc", crc, crc16());
    nvm[0] = 16'h0bad;
    pulse(sd);
    repeat (2) @(negedge clock_i);
    idle();
    chk("crc store", crc, crc16());
    h.rd(7'h43, 8'hf0, 2, d);
    chk("crc read", d, crc16());
    h.wr(7'h43, 8'hf0, 16'h1234, 2);
    chk("crc kept", crc, crc16());
    $display("test load done");
    h.wr(7'h43, 8'hef, 16'h00d5, 1);
    chk("addr", 16'(addr), 16'h0055);
    h.rd(7'h43, 8'hef, 1, d);
    chk("old ack", 16'(h.aok), 16'h0000);
    h.rd(7'h55, 8'hef, 1, d);
    chk("addr read", d, 16'h0055);
    foreach (rsv[k])
    begin
      h.wr(7'h55, 8'hef, 16'(rsv[k]), 1);
      chk("addr kept", 16'(addr), 16'h0055);
    end
    chk("refused", 16'(n_inv), 16'h0005);
    $display("test address done");
    h.wr(7'h55, 8'hf1, 16'h5f9b, 2);
    chk("force", frc, 16'h5f1b);
    h.rd(7'h55, 8'hf1, 2, d);
    chk("inject read", d, 16'h5f9b);
    pulse(fr);
    @(negedge clock_i);
    chk("force drop", frc, 16'h001b);
    h.wr(7'h55, 8'hf1, 16'hdf1b, 2);
    pulse(fr);
    @(negedge clock_i);
    chk("force kept", frc, 16'h5f00);
    ce = 1'b0;
    repeat (2) @(negedge clock_i);
    chk("force off", frc, 16'h0900);
    h.wr(7'h55, 8'hee, 16'h0410, 2);
    h.rd(7'h55, 8'hee, 2, d);
    chk("selector", d, 16'h0410);
    chk("selector out", ssel, 16'h0410);
    $display("test injection done");
    test_done();
  end
  initial
  begin
    #300us;
    n_fail++;
    test_done();
  end
endmodule
